// *** hw/cpu_exception_sequencer.sv ***
/*
 * Cycle-level exception sequencer: reset, interrupts, software trap and
 * unimplemented-opcode trap, with vector fetch, stacking and queue refill.
 * Assumes the integration module drives the vector address onto the bus
 * while vectorReq is high and that memory returns read data in the same cycle.
 */
`timescale 1ns/1ps

// Contract
// - Software trap starts unconditionally, sets I
// - After trap, maskable inhibited until I cleared
// - Same first cycle, then two paths: reset and stacking
// - First cycle fetches vector from table
// - Fetched vector used from third cycle only
// - Vector request asserted, core drives no address
// - Reset cycle two sets S, X, I
// - Reset: three fetches from vector, then run
// - Cycle two pushes 16-bit return address
// - Interrupt return is next unexecuted instruction
// - Trap return is address after opcode
// - Cycle three is first queue refill fetch
// - Cycle four pushes Y, five pushes X
// - Cycle six fetches, joins B:A
// - Cycle seven pushes B:A word
// - Cycle eight pushes condition code, updates masks
// - Non-maskable sets X and I, others I
// - Cycle nine fetches third word, ends
// - Unimplemented opcodes share one fixed vector
// - Frame: cc, B:A+1, X+3, Y+5, return+7
module cpu_exception_sequencer
   import cpu_exc_pkg::*;
(
   input  wire logic                         mclk,          // Core clock, 40 MHz
   input  wire logic                         reset_n,       // Async reset, active low
   input  wire logic                         instrEnd,      // Instruction boundary pulse
   input  wire logic                         swTrapExec,    // Software trap at boundary
   input  wire logic                         unimpExec,     // Unimplemented opcode
   input  wire logic                         irqPending,    // Maskable request
   input  wire logic                         nmiPinN,       // Non-maskable request, low
   input  wire logic [cpu_exc_pkg::ADDR_W-1:0] nextPc,      // Next instruction address
   input  wire logic [cpu_exc_pkg::ADDR_W-1:0] opNextPc,    // Address after opcode
   input  wire logic [cpu_exc_pkg::ACC_W-1:0]  regA,        // Accumulator A
   input  wire logic [cpu_exc_pkg::ACC_W-1:0]  regB,        // Accumulator B
   input  wire logic [cpu_exc_pkg::ADDR_W-1:0] regX,        // Index X
   input  wire logic [cpu_exc_pkg::ADDR_W-1:0] regY,        // Index Y
   input  wire logic [cpu_exc_pkg::ADDR_W-1:0] spIn,        // Stack pointer now
   input  wire logic                         condWrite,     // Core writes condition code
   input  wire logic [cpu_exc_pkg::COND_W-1:0] condWriteData, // Value from core or restore
   input  wire logic [cpu_exc_pkg::ADDR_W-1:0] busRdData,   // Memory read data
   output logic [cpu_exc_pkg::ADDR_W-1:0]      busAddr,     // Address driven by core
   output logic                              busAddrEn,     // Core drives address
   output logic                              busRead,       // Read cycle
   output logic                              busWrite,      // Write cycle
   output logic                              busByte,       // Write is one byte
   output logic [cpu_exc_pkg::ADDR_W-1:0]      busWdata,    // Write data
   output logic                              vectorReq,     // Vector fetch request
   output cpu_exc_pkg::cause_t               excCause,      // Cause of current exception
   output logic                              queueLoad,     // Read data enters queue
   output logic                              execStart,     // Start instruction pulse
   output logic                              excBusy,       // Sequence running
   output logic                              spLoad,        // Load spOut into SP pulse
   output logic [cpu_exc_pkg::ADDR_W-1:0]      spOut,       // Stack pointer after frame
   output logic [cpu_exc_pkg::ADDR_W-1:0]      pcOut,       // Next queue fetch address
   output logic [cpu_exc_pkg::COND_W-1:0]      condCode     // Condition code register
);
   import cpu_exc_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   state_t              state;
   state_t              next_state;
   cause_t              selCause;
   logic                take;
   logic [ADDR_W-1:0]   selRet;
   logic [ADDR_W-1:0]   retAddr;
   logic [ADDR_W-1:0]   vecAddr;
   logic [ADDR_W-1:0]   fetchPtr;
   logic [ADDR_W-1:0]   spWork;
   logic [ADDR_W-1:0]   accWord;
   logic [1:0]          fetchCnt;

   logic [ADDR_W-1:0]   next_busAddr;
   logic                next_busAddrEn;
   logic                next_busRead;
   logic                next_busWrite;
   logic                next_busByte;
   logic [ADDR_W-1:0]   next_busWdata;
   logic                next_vectorReq;
   logic                next_queueLoad;
   logic                next_execStart;
   logic                next_spLoad;
   logic [ADDR_W-1:0]   next_spWork;
   logic [ADDR_W-1:0]   next_fetchPtr;

   exc_path_select u_select (
      .instrEnd   (instrEnd),
      .swTrap     (swTrapExec),
      .unimp      (unimpExec),
      .irqPending (irqPending),
      .nmiPending (!nmiPinN),
      .maskI      (condCode[COND_IMASK_BIT]),
      .maskX      (condCode[COND_XMASK_BIT]),
      .nextPc     (nextPc),
      .opNextPc   (opNextPc),
      .take       (take),
      .cause      (selCause),
      .retAddr    (selRet)
   );

   // ************************************************************
   // Sequencing and bus cycle of the next state
   // ************************************************************
   always_comb begin
      next_state     = state;
      next_busAddr   = ADDR_ZERO;
      next_busAddrEn = 1'b0;
      next_busRead   = 1'b0;
      next_busWrite  = 1'b0;
      next_busByte   = 1'b0;
      next_busWdata  = ADDR_ZERO;
      next_vectorReq = 1'b0;
      next_queueLoad = 1'b0;
      next_execStart = 1'b0;
      next_spLoad    = 1'b0;
      next_spWork    = spWork;
      next_fetchPtr  = fetchPtr;
      case (state)
         S_IDLE: begin
            if (take) begin
               // Same vector cycle for every cause; address left to integration
               next_state     = S_VECTOR;
               next_vectorReq = 1'b1;
               next_busRead   = 1'b1;
               next_spWork    = spIn;
            end
         end
         S_VECTOR: begin
            if (excCause == CAUSE_RESET) begin
               next_state = S_RST_MASK;
            end else begin
               next_state     = S_PUSH_RET;
               next_spWork    = spWork - WORD_STEP;
               next_busAddr   = spWork - WORD_STEP;
               next_busAddrEn = 1'b1;
               next_busWrite  = 1'b1;
               next_busWdata  = retAddr;
            end
         end
         S_RST_MASK: begin
            // Vector is latched; third cycle is the first to use it
            next_state     = S_RST_FETCH;
            next_busAddr   = vecAddr;
            next_busAddrEn = 1'b1;
            next_busRead   = 1'b1;
            next_queueLoad = 1'b1;
            next_fetchPtr  = vecAddr + WORD_STEP;
         end
         S_RST_FETCH: begin
            if (fetchCnt == FETCH_LAST) begin
               next_state     = S_IDLE;
               next_execStart = 1'b1;
            end else begin
               next_busAddr   = fetchPtr;
               next_busAddrEn = 1'b1;
               next_busRead   = 1'b1;
               next_queueLoad = 1'b1;
               next_fetchPtr  = fetchPtr + WORD_STEP;
            end
         end
         S_PUSH_RET: begin
            next_state     = S_FETCH1;
            next_busAddr   = vecAddr;
            next_busAddrEn = 1'b1;
            next_busRead   = 1'b1;
            next_queueLoad = 1'b1;
            next_fetchPtr  = vecAddr + WORD_STEP;
         end
         S_FETCH1: begin
            next_state     = S_PUSH_Y;
            next_spWork    = spWork - WORD_STEP;
            next_busAddr   = spWork - WORD_STEP;
            next_busAddrEn = 1'b1;
            next_busWrite  = 1'b1;
            next_busWdata  = regY;
         end
         S_PUSH_Y: begin
            next_state     = S_PUSH_X;
            next_spWork    = spWork - WORD_STEP;
            next_busAddr   = spWork - WORD_STEP;
            next_busAddrEn = 1'b1;
            next_busWrite  = 1'b1;
            next_busWdata  = regX;
         end
         S_PUSH_X: begin
            next_state     = S_FETCH2;
            next_busAddr   = fetchPtr;
            next_busAddrEn = 1'b1;
            next_busRead   = 1'b1;
            next_queueLoad = 1'b1;
            next_fetchPtr  = fetchPtr + WORD_STEP;
         end
         S_FETCH2: begin
            next_state     = S_PUSH_D;
            next_spWork    = spWork - WORD_STEP;
            next_busAddr   = spWork - WORD_STEP;
            next_busAddrEn = 1'b1;
            next_busWrite  = 1'b1;
            next_busWdata  = accWord;
         end
         S_PUSH_D: begin
            // Condition code is a single byte, so the pointer moves by one
            next_state     = S_PUSH_CC;
            next_spWork    = spWork - BYTE_STEP;
            next_busAddr   = spWork - BYTE_STEP;
            next_busAddrEn = 1'b1;
            next_busWrite  = 1'b1;
            next_busByte   = 1'b1;
            next_busWdata  = {8'h00, condCode};
         end
         S_PUSH_CC: begin
            next_state     = S_FETCH3;
            next_busAddr   = fetchPtr;
            next_busAddrEn = 1'b1;
            next_busRead   = 1'b1;
            next_queueLoad = 1'b1;
            next_fetchPtr  = fetchPtr + WORD_STEP;
         end
         S_FETCH3: begin
            next_state     = S_IDLE;
            next_execStart = 1'b1;
            next_spLoad    = 1'b1;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // ************************************************************
   // State register; reset enters the sequence at the vector cycle
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_VECTOR;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Bus and control outputs, one cycle per state
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busAddr   <= ADDR_ZERO;
         busAddrEn <= 1'b0;
         busRead   <= 1'b1;
         busWrite  <= 1'b0;
         busByte   <= 1'b0;
         busWdata  <= ADDR_ZERO;
         vectorReq <= 1'b1;
         queueLoad <= 1'b0;
         execStart <= 1'b0;
         spLoad    <= 1'b0;
      end else begin
         busAddr   <= next_busAddr;
         busAddrEn <= next_busAddrEn;
         busRead   <= next_busRead;
         busWrite  <= next_busWrite;
         busByte   <= next_busByte;
         busWdata  <= next_busWdata;
         vectorReq <= next_vectorReq;
         queueLoad <= next_queueLoad;
         execStart <= next_execStart;
         spLoad    <= next_spLoad;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         excBusy <= 1'b1;
      end else begin
         excBusy <= (next_state != S_IDLE);
      end
   end

   // ************************************************************
   // Cause and return address caught at the boundary
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         excCause <= CAUSE_RESET;
         retAddr  <= ADDR_ZERO;
      end else if (state == S_IDLE && take) begin
         excCause <= selCause;
         retAddr  <= selRet;
      end
   end

   // ************************************************************
   // Vector, queue pointer, stack pointer and B:A word
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         vecAddr <= ADDR_ZERO;
      end else if (state == S_VECTOR) begin
         vecAddr <= busRdData;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fetchPtr <= ADDR_ZERO;
         spWork   <= ADDR_ZERO;
      end else begin
         fetchPtr <= next_fetchPtr;
         spWork   <= next_spWork;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fetchCnt <= 2'h0;
      end else if (state == S_RST_FETCH) begin
         fetchCnt <= fetchCnt + 2'h1;
      end else begin
         fetchCnt <= 2'h0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         accWord <= ADDR_ZERO;
      end else if (state == S_PUSH_X) begin
         // Joined entering the second refill fetch so the next push sees it
         accWord <= {regB, regA};
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         spOut <= ADDR_ZERO;
         pcOut <= ADDR_ZERO;
      end else begin
         spOut <= next_spWork;
         pcOut <= next_fetchPtr;
      end
   end

   // ************************************************************
   // Condition code: sequencer mask updates win over core writes
   // ************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         condCode <= COND_RESET;
      end else if (state == S_RST_MASK) begin
         condCode[COND_STOP_BIT]  <= 1'b1;
         condCode[COND_XMASK_BIT] <= 1'b1;
         condCode[COND_IMASK_BIT] <= 1'b1;
      end else if (state == S_PUSH_CC) begin
         // Update only after the old value has gone to the stack
         condCode[COND_IMASK_BIT] <= 1'b1;
         if (excCause == CAUSE_NMI) begin
            condCode[COND_XMASK_BIT] <= 1'b1;
         end
      end else if (condWrite) begin
         // X can be cleared by software but not set by it
         condCode <= condWriteData;
         condCode[COND_XMASK_BIT] <= condWriteData[COND_XMASK_BIT]
                                     & condCode[COND_XMASK_BIT];
      end
   end

endmodule

// *** hw/cpu_exc_pkg.sv ***
/*
 * Shared constants and types for the exception sequencer of the 16-bit core.
 * Assumes a 16-bit address bus, 8-bit accumulators and an 8-bit condition code.
 */
package cpu_exc_pkg;

   // ************************************************************
   // Widths and steps
   // ************************************************************
   localparam int          ADDR_W    = 16;
   localparam int          ACC_W     = 8;
   localparam int          COND_W    = 8;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] ADDR_ZERO = 16'h0000;

   // ************************************************************
   // Condition code field positions and reset value
   // ************************************************************
   localparam int         COND_STOP_BIT = 7;
   localparam int         COND_XMASK_BIT = 6;
   localparam int         COND_IMASK_BIT = 4;
   localparam logic [7:0] COND_RESET     = 8'hd0;

   // Shared vector of all unimplemented second-page opcodes
   localparam logic [15:0] TRAP_VECTOR = 16'hfff8;

   // Reset refills the queue with this many program-word fetches after the first
   localparam logic [1:0] FETCH_LAST = 2'h2;

   typedef enum logic [2:0] {
      CAUSE_NONE,
      CAUSE_RESET,
      CAUSE_IRQ,
      CAUSE_NMI,
      CAUSE_SWTRAP,
      CAUSE_UNIMP
   } cause_t;

   typedef enum logic [3:0] {
      S_IDLE,
      S_VECTOR,
      S_RST_MASK,
      S_RST_FETCH,
      S_PUSH_RET,
      S_FETCH1,
      S_PUSH_Y,
      S_PUSH_X,
      S_FETCH2,
      S_PUSH_D,
      S_PUSH_CC,
      S_FETCH3
   } state_t;

endpackage

// *** hw/exc_path_select.sv ***
/*
 * Chooses the exception to take at an instruction boundary and its return address.
 * Assumes boundary, trap and request flags are synchronous to the core clock.
 */
`timescale 1ns/1ps
module exc_path_select
   import cpu_exc_pkg::*;
(
   input  wire logic              instrEnd,    // Instruction boundary pulse
   input  wire logic              swTrap,      // Software trap instruction executing
   input  wire logic              unimp,       // Unimplemented opcode executing
   input  wire logic              irqPending,  // Maskable request pending
   input  wire logic              nmiPending,  // Non-maskable request pending
   input  wire logic              maskI,       // Maskable mask bit
   input  wire logic              maskX,       // Non-maskable mask bit
   input  wire logic [ADDR_W-1:0] nextPc,      // Next instruction address
   input  wire logic [ADDR_W-1:0] opNextPc,    // Address after trapping opcode
   output logic                   take,        // Start exception now
   output cause_t                 cause,       // Chosen cause
   output logic [ADDR_W-1:0]      retAddr      // Return address to stack
);

   always_comb begin
      take    = 1'b0;
      cause   = CAUSE_NONE;
      retAddr = nextPc;
      if (instrEnd) begin
         // Traps come from the instruction itself, so no mask can hold them
         if (swTrap) begin
            take    = 1'b1;
            cause   = CAUSE_SWTRAP;
            retAddr = opNextPc;
         end else if (unimp) begin
            take    = 1'b1;
            cause   = CAUSE_UNIMP;
            retAddr = opNextPc;
         end else if (nmiPending && !maskX) begin
            take  = 1'b1;
            cause = CAUSE_NMI;
         end else if (irqPending && !maskI) begin
            take  = 1'b1;
            cause = CAUSE_IRQ;
         end
      end
   end

endmodule

// *** tb/exc_mem_model.sv ***
/* Far side of the sequencer: memory with same-cycle read data and the
   integration logic that answers a vector request. Assumes one clock. */
`timescale 1ns/1ps
module exc_mem_model
   import cpu_exc_pkg::*;
(
   input  wire logic        mclk,      // Core clock
   input  wire logic [15:0] busAddr,   // Core address
   input  wire logic        busAddrEn, // Core drives address
   input  wire logic        busRead,   // Read cycle
   input  wire logic        busWrite,  // Write cycle
   input  wire logic        busByte,   // Byte write
   input  wire logic [15:0] busWdata,  // Write data
   input  wire logic        vectorReq, // Vector fetch
   input  cause_t           excCause,  // Cause of the sequence
   output logic [15:0]      busRdData  // Read data or vector
);
   logic [7:0]  mem [0:65535];
   logic [15:0] lastRd = 16'h0000;

   always_comb begin
      if (vectorReq) begin
         busRdData = {1'b0, excCause, 12'h100};
      end else if (busRead && busAddrEn) begin
         busRdData = ~busAddr;
      end else begin
         busRdData = ~lastRd; // Idle bus toggles so stale data never looks valid
      end
   end

   always @(posedge mclk) begin
      lastRd <= busRdData;
      if (busWrite && busAddrEn && busByte) begin
         mem[busAddr] <= busWdata[7:0];
      end else if (busWrite && busAddrEn) begin
         mem[busAddr] <= busWdata[15:8];
         mem[busAddr + 16'h0001] <= busWdata[7:0];
      end
   end
endmodule

// *** tb/exc_seq_chk.sv ***
/* Checker for the exception sequencer: bus order, frame and masks.
   Bound to the sequencer; spIn, nextPc and opNextPc held steady by the bench. */
`timescale 1ns/1ps
module exc_seq_chk
   import cpu_exc_pkg::*;
(
   input wire logic        mclk, reset_n, instrEnd, swTrapExec, unimpExec, nmiPinN,
   input wire logic        busAddrEn, busRead, busWrite, busByte, vectorReq, queueLoad,
   input wire logic        execStart, excBusy, spLoad,
   input wire logic [7:0]  regA, regB, condCode,
   input wire logic [15:0] nextPc, opNextPc, regX, regY, spIn, busRdData, busAddr,
   input wire logic [15:0] busWdata, spOut, pcOut,
   input cause_t           excCause
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire logic isInt = excCause == CAUSE_IRQ || excCause == CAUSE_NMI;
   wire logic trapVec = vectorReq && excCause != CAUSE_RESET;

   vec_noaddr_a: assert property (vectorReq |-> !busAddrEn && busRead)
      else $error("vector cycle drives an address");
   sw_take_a: assert property (
      instrEnd && !excBusy && swTrapExec |=> vectorReq && excCause == CAUSE_SWTRAP)
      else $error("software trap not taken");
   mask_hold_a: assert property (
      instrEnd && !excBusy && condCode[4] && !swTrapExec && !unimpExec && nmiPinN |=> !vectorReq)
      else $error("masked request taken");
   rst_path_a: assert property (vectorReq && excCause == CAUSE_RESET |=> !busWrite ##1
      condCode[7] && condCode[6] && condCode[4] && queueLoad && busAddr == $past(busRdData, 2))
      else $error("reset path wrong");
   ret_push_a: assert property (trapVec |=> busWrite && !busByte &&
      busAddr == spIn - WORD_STEP && busWdata == (isInt ? nextPc : opNextPc))
      else $error("return address push wrong");
   fetch_one_a: assert property (
      trapVec |=> ##1 busRead && queueLoad && busAddr == $past(busRdData, 2))
      else $error("first refill fetch wrong");
   stack_order_a: assert property (trapVec |=> ##2 busWdata == regY &&
      busAddr == spIn - 16'h0004 ##1 busWdata == regX ##1 queueLoad ##1 busWdata == {regB, regA}
      ##1 busWrite && busByte && busAddr == spIn - 16'h0009) else $error("stacking order wrong");
   mask_upd_a: assert property (busWrite && busByte |-> busWdata[7:0] == condCode ##1
      condCode[4] && condCode[6] == (excCause == CAUSE_NMI || $past(condCode[6])))
      else $error("mask update wrong");
   end_fetch_a: assert property (execStart |-> $past(queueLoad) && $past(busRead) &&
      !excBusy && pcOut == $past(busAddr) + WORD_STEP) else $error("sequence end wrong");
   frame_sp_a: assert property (spLoad |-> execStart && spOut == spIn - 16'h0009)
      else $error("frame pointer wrong");
endmodule

bind cpu_exception_sequencer exc_seq_chk u_exc_seq_chk (.*);

// *** tb/tb.sv ***
/* Bench for the exception sequencer: reset, masked request, interrupts,
   traps and an aborted sequence against the memory model. */
`timescale 1ns/1ps
module tb;
   import cpu_exc_pkg::*;
   logic        mclk = 1'b0, reset_n = 1'b0, instrEnd = 1'b0, swTrapExec = 1'b0;
   logic        unimpExec = 1'b0, irqPending = 1'b0, nmiPinN = 1'b1, condWrite = 1'b0;
   logic [7:0]  regA = 8'h3c, regB = 8'hc3, condWriteData = 8'h00, condCode;
   logic [15:0] nextPc = 16'h1234, opNextPc = 16'h1236, regX = 16'ha55a, regY = 16'h5aa5;
   logic [15:0] spIn = 16'h0800, busRdData, busAddr, busWdata, spOut, pcOut;
   logic        busAddrEn, busRead, busWrite, busByte, vectorReq, queueLoad, execStart;
   logic        excBusy, spLoad;
   cause_t      excCause;
   int          errors = 0, samples_checked = 0, cycles = 0;

   cpu_exception_sequencer u_cpu_exception_sequencer (.*);
   exc_mem_model           u_exc_mem_model (.*);

   initial forever #12.5 mclk = ~mclk;

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic logic [15:0] word(input logic [15:0] a);
      return {u_exc_mem_model.mem[int'(a)], u_exc_mem_model.mem[int'(a) + 1]};
   endfunction

   task automatic waitStart();
      int n;
      n = 0;
      while (execStart !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      check({15'h0000, execStart}, 16'h0001);
   endtask

   task automatic clearMasks();
      condWrite = 1'b1;
      step(1);
      condWrite = 1'b0;
   endtask

   task automatic t_reset(input int hold);
      reset_n = 1'b0;
      step(hold);
      reset_n = 1'b1;
      waitStart();
      check(pcOut, 16'h1106);
      check({8'h00, condCode & 8'hd0}, 16'h00d0);
   endtask

   // One exception from boundary to completion, then the frame and masks
   task automatic run(input logic sw, un, irq, nmiN, input logic [15:0] vec, ret);
      logic [7:0] cc;
      cc = condCode;
      {swTrapExec, unimpExec, irqPending, nmiPinN, instrEnd} = {sw, un, irq, nmiN, 1'b1};
      step(1);
      {swTrapExec, unimpExec, instrEnd} = 3'h0;
      waitStart();
      {irqPending, nmiPinN} = 2'h1;
      check({15'h0000, spLoad}, 16'h0001);
      check(spOut, spIn - 16'h0009);
      check(pcOut, vec + 16'h0006);
      check(word(spIn - 16'h0002), ret);
      check(word(spIn - 16'h0004), regY);
      check(word(spIn - 16'h0006), regX);
      check(word(spIn - 16'h0008), {regB, regA});
      check({8'h00, u_exc_mem_model.mem[int'(spIn) - 9]}, {8'h00, cc});
      check({8'h00, condCode & 8'h50}, {8'h00, (cc & 8'h40) | (nmiN ? 8'h10 : 8'h50)});
   endtask

   task automatic t_masked();
      {irqPending, instrEnd} = 2'h3;
      step(1);
      instrEnd = 1'b0;
      step(2);
      check({15'h0000, excBusy | vectorReq}, 16'h0000);
      irqPending = 1'b0;
   endtask

   task automatic t_interrupts();
      clearMasks();
      run(1'b0, 1'b0, 1'b1, 1'b1, 16'h2100, nextPc);
      clearMasks();
      run(1'b0, 1'b0, 1'b0, 1'b0, 16'h3100, nextPc);
   endtask

   task automatic t_traps();
      step(1);
      run(1'b1, 1'b0, 1'b0, 1'b1, 16'h4100, opNextPc);
      clearMasks();
      run(1'b0, 1'b1, 1'b1, 1'b1, 16'h5100, opNextPc);
   endtask

   task automatic t_abort();
      clearMasks();
      {irqPending, instrEnd} = 2'h3;
      step(1);
      instrEnd = 1'b0;
      step(4);
      irqPending = 1'b0;
      t_reset(2);
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         conclude();
      end
   end

   initial begin
      t_reset(16);
      t_masked();
      t_interrupts();
      t_traps();
      t_abort();
      conclude();
   end
endmodule
